/* File: shared/frl_defines.vh */
// constants for the flush, refetch and atomic lock block
// assumes 64-bit program memory words of four 16-bit packages
`ifndef FRL_DEFINES_VH
`define FRL_DEFINES_VH
`define FRL_WORD_W 64
`define FRL_PKG_W 16
`define FRL_PKGS 4
`define FRL_ADDR_W 24
`define FRL_ADDR_STEP 24'h000008
`define FRL_LEN_W 2
`define FRL_CNT_W 3
`define FRL_FIFO_DEPTH 16
`define FRL_OP_NONE 3'h0
`define FRL_OP_ATOMIC 3'h1
`define FRL_OP_EXT_REG 3'h2
`define FRL_OP_EXT_PAGE 3'h3
`define FRL_OP_EXT_SEG 3'h4
`define FRL_OP_EXT_PAGE_REG 3'h5
`define FRL_OP_EXT_SEG_REG 3'h6
`endif

/* File: verilog/frl_fifo.v */
// parameterised valid/ready fifo for instruction packages
// assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module frl_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire do_wr;
  wire do_rd;
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data = mem[rd_ff];
  assign do_wr = in_valid && in_ready && !flush;
  assign do_rd = out_valid && out_ready && !flush;
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ff] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // frl_fifo
`default_nettype wire

/* File: verilog/frl_top.v */
// flush/refetch control and atomic or extend sequence lock
// assumes program memory answers one cycle after the address strobe
// Overview of operation
// - mispredict cancels pipeline and queued instructions
// - refetch restarts at target, old buffers dropped
// - target address sent next cycle, data after
// - memory word is four 16-bit packages
// - straddling target needs second fetch, joined
// - completed target bypasses queue to decode
// - keep prefetching; buffer feeds decode before queue
// - sequence blocks interrupts, transfers, class A traps; code gates only irq_pending
// - two-bit field gives one to four instructions
// - extend instructions alter operand addressing
// - lock effective for very next instruction
// - count each instruction once, regardless of cycles
// - every instruction class is counted
// - class B trap ends sequence, unlocks
// - resumed instructions run unlocked, normal addressing
// - single counter, nested instruction reloads it
`timescale 1ns/100ps
`default_nettype none
`include "frl_defines.vh"
module frl_top #(
  parameter FIFO_DEPTH = `FRL_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire rst,
  input wire mispredict,
  input wire [`FRL_ADDR_W-1:0] target_addr,
  output reg pmu_req_ff,
  output reg [`FRL_ADDR_W-1:0] pmu_addr_ff,
  input wire pmu_data_valid,
  input wire [`FRL_WORD_W-1:0] pmu_data,
  output reg pipe_cancel_ff,
  output reg dec_valid_ff,
  output reg [2*`FRL_PKG_W-1:0] dec_instr_ff,
  output reg dec_from_buffer_ff,
  input wire dec_ready,
  input wire instr_done,
  input wire [`FRL_CNT_W-1:0] instr_op,
  input wire [`FRL_LEN_W-1:0] sequence_length_field,
  input wire class_b_trap,
  input wire irq_pending,
  output reg irq_lock_ff,
  output reg irq_eligible_ff,
  output reg [`FRL_CNT_W-1:0] ext_mode_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`FRL_PKG_W-1:0] buf_ff [0:`FRL_PKGS-1];
  reg [2:0] buf_cnt_ff;
  reg [1:0] buf_rd_ff;
  reg first_ff;
  reg [`FRL_PKG_W-1:0] half_ff;
  reg half_ok_ff;
  // address moved at the last edge, so the word on the bus is stale
  reg addr_chg_ff;
  reg [`FRL_CNT_W-1:0] seq_cnt_ff;
  reg [`FRL_CNT_W-1:0] nxt_seq_cnt;
  reg [`FRL_CNT_W-1:0] nxt_mode;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`FRL_PKG_W-1:0] fifo_out_data;
  wire fifo_pop;
  wire buf_has;
  wire take_dec;
  wire [`FRL_PKG_W-1:0] buf_head;
  function is_lock_op;
    input [`FRL_CNT_W-1:0] op;
    begin
      is_lock_op = (op >= `FRL_OP_ATOMIC) && (op <= `FRL_OP_EXT_SEG_REG);
    end
  endfunction
  assign buf_has = (buf_cnt_ff != 3'h0);
  assign buf_head = buf_ff[buf_rd_ff];
  assign take_dec = !dec_valid_ff || dec_ready;
  // queue supplies decode only when fetch buffer is empty
  assign fifo_pop = take_dec && !buf_has && !half_ok_ff && (state_ff == ST_RUN);
  frl_fifo #(
    .WIDTH(`FRL_PKG_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(mispredict),
    .in_valid(pmu_data_valid && buf_has && (state_ff == ST_RUN) && !take_dec),
    .in_ready(fifo_in_ready),
    .in_data(buf_head),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_WAIT: if (pmu_data_valid && !addr_chg_ff) nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_IDLE;
    endcase
    if (mispredict) begin
      nxt_state = ST_WAIT;
    end
  end
  // fetch side: address, package buffer, decode hand-off
  always @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      pmu_req_ff <= 1'b0;
      pmu_addr_ff <= {`FRL_ADDR_W{1'b0}};
      pipe_cancel_ff <= 1'b0;
      dec_valid_ff <= 1'b0;
      dec_instr_ff <= {(2*`FRL_PKG_W){1'b0}};
      dec_from_buffer_ff <= 1'b0;
      buf_cnt_ff <= 3'h0;
      buf_rd_ff <= 2'h0;
      first_ff <= 1'b0;
      half_ff <= {`FRL_PKG_W{1'b0}};
      half_ok_ff <= 1'b0;
      addr_chg_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pipe_cancel_ff <= mispredict;
      addr_chg_ff <= 1'b0;
      if (take_dec) begin
        dec_valid_ff <= 1'b0;
      end
      if (mispredict) begin
        pmu_req_ff <= 1'b1;
        pmu_addr_ff <= {target_addr[`FRL_ADDR_W-1:3], 3'h0};
        addr_chg_ff <= 1'b1;
        buf_cnt_ff <= 3'h0;
        buf_rd_ff <= target_addr[2:1];
        first_ff <= 1'b1;
        half_ok_ff <= 1'b0;
        dec_valid_ff <= 1'b0;
      end else begin
        // wrong-path or stale words are never captured
        if (pmu_data_valid && (state_ff != ST_IDLE) && !buf_has && !addr_chg_ff) begin
          pmu_addr_ff <= pmu_addr_ff + `FRL_ADDR_STEP;
          addr_chg_ff <= 1'b1;
          // four packages per word
          buf_ff[0] <= pmu_data[15:0];
          buf_ff[1] <= pmu_data[31:16];
          buf_ff[2] <= pmu_data[47:32];
          buf_ff[3] <= pmu_data[63:48];
          buf_cnt_ff <= first_ff ? (3'h4 - {1'b0, buf_rd_ff}) : 3'h4;
          if (!first_ff) begin
            buf_rd_ff <= 2'h0;
          end
        end else if (buf_has && take_dec && state_ff == ST_RUN) begin
          if (first_ff && buf_cnt_ff == 3'h1 && !half_ok_ff) begin
            half_ff <= buf_head;
            half_ok_ff <= 1'b1;
          end else if (half_ok_ff) begin
            dec_valid_ff <= 1'b1;
            dec_instr_ff <= {buf_head, half_ff};
            dec_from_buffer_ff <= 1'b1;
            half_ok_ff <= 1'b0;
            first_ff <= 1'b0;
          end else begin
            dec_valid_ff <= 1'b1;
            dec_instr_ff <= {{`FRL_PKG_W{1'b0}}, buf_head};
            dec_from_buffer_ff <= 1'b1;
            first_ff <= 1'b0;
          end
          buf_cnt_ff <= buf_cnt_ff - 3'h1;
          buf_rd_ff <= buf_rd_ff + 2'h1;
        end else if (buf_has && !take_dec && fifo_in_ready && state_ff == ST_RUN) begin
          buf_cnt_ff <= buf_cnt_ff - 3'h1;
          buf_rd_ff <= buf_rd_ff + 2'h1;
        end
        if (fifo_pop && fifo_out_valid) begin
          dec_valid_ff <= 1'b1;
          dec_instr_ff <= {{`FRL_PKG_W{1'b0}}, fifo_out_data};
          dec_from_buffer_ff <= 1'b0;
        end
      end
    end
  end
  // sequence counter and lock
  always @* begin
    nxt_seq_cnt = seq_cnt_ff;
    nxt_mode = ext_mode_ff;
    if (instr_done) begin
      if (seq_cnt_ff != 3'h0) begin
        nxt_seq_cnt = seq_cnt_ff - 3'h1;
        if (seq_cnt_ff == 3'h1) begin
          nxt_mode = `FRL_OP_NONE;
        end
      end
      if (is_lock_op(instr_op)) begin
        nxt_seq_cnt = {1'b0, sequence_length_field} + 3'h1;
        nxt_mode = (instr_op == `FRL_OP_ATOMIC) ? `FRL_OP_NONE : instr_op;
      end
    end
    if (class_b_trap) begin
      nxt_seq_cnt = 3'h0;
      nxt_mode = `FRL_OP_NONE;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      seq_cnt_ff <= 3'h0;
      ext_mode_ff <= `FRL_OP_NONE;
      irq_lock_ff <= 1'b0;
      irq_eligible_ff <= 1'b0;
    end else begin
      seq_cnt_ff <= nxt_seq_cnt;
      ext_mode_ff <= nxt_mode;
      irq_lock_ff <= (nxt_seq_cnt != 3'h0);
      irq_eligible_ff <= irq_pending && (nxt_seq_cnt == 3'h0);
    end
  end
endmodule // frl_top
`default_nettype wire

/* File: tb/frl_assertions.sv */
// checker for the flush/refetch and sequence lock block
// assumes binding onto frl_top, single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "frl_defines.vh"
module frl_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic mispredict,
  input wire logic [`FRL_ADDR_W-1:0] target_addr,
  input wire logic pmu_req_ff,
  input wire logic [`FRL_ADDR_W-1:0] pmu_addr_ff,
  input wire logic pipe_cancel_ff,
  input wire logic dec_valid_ff,
  input wire logic [2*`FRL_PKG_W-1:0] dec_instr_ff,
  input wire logic dec_ready,
  input wire logic instr_done,
  input wire logic [`FRL_CNT_W-1:0] instr_op,
  input wire logic class_b_trap,
  input wire logic irq_lock_ff,
  input wire logic irq_eligible_ff,
  input wire logic [`FRL_CNT_W-1:0] ext_mode_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_cancel_pulse: assert property (mispredict |=> pipe_cancel_ff)
    else $error("no cancel after mispredict");
  chk_refetch_addr: assert property (mispredict |=> pmu_req_ff
    && pmu_addr_ff == ($past(target_addr) & 24'hFFFFF8)) else $error("bad refetch address");
  chk_lock_next: assert property (instr_done && instr_op != 3'h0 && !class_b_trap
    |=> irq_lock_ff) else $error("lock late");
  chk_ext_mode: assert property (instr_done && instr_op > 3'h1 && !class_b_trap
    |=> ext_mode_ff == $past(instr_op)) else $error("addressing mode wrong");
  chk_trap_clear: assert property (class_b_trap |=> !irq_lock_ff && ext_mode_ff == 3'h0)
    else $error("trap left lock");
  chk_lock_holds: assert property (irq_lock_ff && !instr_done && !class_b_trap
    |=> irq_lock_ff) else $error("lock dropped without instruction");
  chk_block_irq: assert property (irq_lock_ff |-> !irq_eligible_ff)
    else $error("eligible while locked");
  chk_dec_hold: assert property (dec_valid_ff && !dec_ready && !mispredict && !pipe_cancel_ff
    |=> dec_valid_ff && $stable(dec_instr_ff)) else $error("decode handoff dropped");
endmodule // frl_assertions
`default_nettype wire

/* File: tb/frl_pmu_model.sv */
// zero-wait program memory model, package value equals its address
// assumes requests come from frl_top on clk
`timescale 1ns/100ps
`default_nettype none
module frl_pmu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [23:0] addr,
  output logic valid,
  output logic [63:0] data
);
  logic [15:0] a_ff;
  logic [63:0] word;
  always @(posedge clk) begin
    valid <= req && !rst;
    a_ff <= addr[15:0];
  end
  assign word = {a_ff + 16'h0006, a_ff + 16'h0004, a_ff + 16'h0002, a_ff};
  assign data = valid ? word : ~word;
endmodule // frl_pmu_model
`default_nettype wire

/* File: tb/frl_top_tb.sv */
// bench for frl_top with memory model and checker
// assumes 125 MHz clk, sync reset held 4 cycles
`timescale 1ns/100ps
`default_nettype none
module frl_top_tb;
  logic clk = 0, rst = 1, mispredict = 0, dec_ready = 0, instr_done = 0;
  logic class_b_trap = 0, irq_pending = 0, pmu_req_ff, pmu_data_valid, pipe_cancel_ff;
  logic dec_valid_ff, dec_from_buffer_ff, irq_lock_ff, irq_eligible_ff;
  logic [23:0] target_addr = 24'h0, pmu_addr_ff;
  logic [63:0] pmu_data;
  logic [31:0] dec_instr_ff;
  logic [2:0] instr_op = 3'h0, ext_mode_ff;
  logic [1:0] sequence_length_field = 2'h0;
  int failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  frl_top DUT (.clk(clk), .rst(rst), .mispredict(mispredict), .target_addr(target_addr),
    .pmu_req_ff(pmu_req_ff), .pmu_addr_ff(pmu_addr_ff), .pmu_data_valid(pmu_data_valid),
    .pmu_data(pmu_data), .pipe_cancel_ff(pipe_cancel_ff), .dec_valid_ff(dec_valid_ff),
    .dec_instr_ff(dec_instr_ff), .dec_from_buffer_ff(dec_from_buffer_ff),
    .dec_ready(dec_ready), .instr_done(instr_done), .instr_op(instr_op),
    .sequence_length_field(sequence_length_field), .class_b_trap(class_b_trap),
    .irq_pending(irq_pending), .irq_lock_ff(irq_lock_ff), .irq_eligible_ff(irq_eligible_ff),
    .ext_mode_ff(ext_mode_ff));
  frl_pmu_model pmu (.clk(clk), .rst(rst), .req(pmu_req_ff), .addr(pmu_addr_ff),
    .valid(pmu_data_valid), .data(pmu_data));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wrap_up;
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task step(input logic [2:0] op, input logic [1:0] len);
    @(negedge clk) begin instr_done = 1; instr_op = op; sequence_length_field = len; end
    @(negedge clk) begin instr_done = 0; instr_op = 3'h0; end
  endtask
  // lock for len+1 instructions, each spaced by two idle cycles
  task t_lock(input logic [2:0] op, input logic [1:0] len);
    step(op, len);
    chk("ext_mode", (op > 3'h1) ? op : 3'h0, ext_mode_ff);
    for (int i = 0; i <= len; i++) begin
      chk("lock", 1, irq_lock_ff);
      @(negedge clk);
      step(3'h0, 2'h0);
    end
    chk("lock end", 0, irq_lock_ff);
    chk("mode end", 0, ext_mode_ff);
  endtask
  task t_nest_pend;
    irq_pending = 1;
    step(3'h1, 2'h3);
    step(3'h0, 2'h0);
    chk("eligible", 0, irq_eligible_ff);
    step(3'h5, 2'h0);
    step(3'h0, 2'h0);
    chk("nest end", 0, irq_lock_ff);
    @(negedge clk) chk("eligible", 1, irq_eligible_ff);
    irq_pending = 0;
  endtask
  task t_trap;
    step(3'h6, 2'h3);
    @(negedge clk) class_b_trap = 1;
    @(negedge clk) class_b_trap = 0;
    chk("trap lock", 0, irq_lock_ff);
    step(3'h0, 2'h0);
    chk("after trap", 0, {irq_lock_ff, ext_mode_ff});
  endtask
  task t_flush(input logic [23:0] t);
    int n;
    @(negedge clk) begin mispredict = 1; target_addr = t; end
    @(negedge clk) mispredict = 0;
    chk("cancel", 1, pipe_cancel_ff);
    chk("addr", t & 24'hFFFFF8, pmu_addr_ff);
    n = 0;
    while (dec_valid_ff !== 1'b1 && n < 20) @(negedge clk) n++;
    if (n == 20) begin failures++; wrap_up; end
    if (t[2:1] == 2'h3) chk("joined", {t[15:0] + 16'h2, t[15:0]}, dec_instr_ff);
    else chk("target", t[15:0], dec_instr_ff[15:0]);
    chk("from buffer", 1, dec_from_buffer_ff);
    dec_ready = 1;
    @(negedge clk) dec_ready = 0;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    for (int k = 1; k <= 6; k++) t_lock(k[2:0], k[1:0]);
    t_nest_pend;
    t_trap;
    t_flush(24'h001234);
    t_flush(24'h00205E);
    wrap_up;
  end
endmodule // frl_top_tb
bind frl_top frl_assertions chk (.clk(clk), .rst(rst), .mispredict(mispredict),
  .target_addr(target_addr), .pmu_req_ff(pmu_req_ff), .pmu_addr_ff(pmu_addr_ff),
  .pipe_cancel_ff(pipe_cancel_ff), .dec_valid_ff(dec_valid_ff), .dec_instr_ff(dec_instr_ff),
  .dec_ready(dec_ready), .instr_done(instr_done), .instr_op(instr_op),
  .class_b_trap(class_b_trap), .irq_lock_ff(irq_lock_ff), .irq_eligible_ff(irq_eligible_ff),
  .ext_mode_ff(ext_mode_ff));
`default_nettype wire
